/* File: design/ccpu_pkg.sv */
// Purpose: shared constants for the compare/pwm unit and its timer-side partner
// Assumes: 8-bit register writes from software, 16-bit timer one count
// Notes: mode codes for toggle/set/clear/pwm follow the unit control register layout
package ccpu_pkg;
    // register indices on the avalon side of the partner end
    localparam logic [2:0] CCPU_REG_CONTROL = 3'h0;
    localparam logic [2:0] CCPU_REG_CMP_LOW = 3'h1;
    localparam logic [2:0] CCPU_REG_CMP_HIGH = 3'h2;
    localparam logic [2:0] CCPU_REG_PERIOD = 3'h3;
    localparam logic [2:0] CCPU_REG_TIMER_CTRL = 3'h4;
    localparam logic [2:0] CCPU_REG_STATUS = 3'h5;
    localparam logic [2:0] CCPU_REG_TIMER_LOW = 3'h6;
    localparam logic [2:0] CCPU_REG_TIMER_HIGH = 3'h7;
    // unit control fields
    localparam int CCPU_MODE_LSB = 0;
    localparam int CCPU_DUTY_LSB = 4;
    localparam logic [7:0] CCPU_CONTROL_RESET = 8'h00;
    // action mode encodings
    localparam logic [3:0] CCPU_MODE_OFF = 4'h0;
    localparam logic [3:0] CCPU_MODE_TOGGLE = 4'h2;
    localparam logic [3:0] CCPU_MODE_SET = 4'h8;
    localparam logic [3:0] CCPU_MODE_CLEAR = 4'h9;
    localparam logic [3:0] CCPU_MODE_SWINT = 4'hA;
    localparam logic [3:0] CCPU_MODE_TRIGGER = 4'hB;
    localparam logic [1:0] CCPU_MODE_PWM_TOP = 2'h3;
    // status fields
    localparam int CCPU_ST_MATCH = 0;
    localparam int CCPU_ST_OVF = 1;
    localparam int CCPU_ST_ADC = 2;
    localparam int CCPU_ST_PIN = 3;
    // timer control fields
    localparam int CCPU_TC_T1_ON = 0;
    localparam int CCPU_TC_PT_ON = 1;
    localparam int CCPU_TC_ADC_EN = 2;
    localparam int CCPU_TC_T1_DIV_LSB = 4;
endpackage

/* File: design/ccpu_link_if.sv */
// Purpose: link between the unit and its timer/adc/pin partner
// Assumes: single clock domain
// Notes: unit drives pin ownership, trigger and flag; partner drives counts and registers
`timescale 1ns/10ps
`default_nettype none
interface ccpu_link_if;
    logic [7:0] unit_control;
    logic [7:0] compare_value_low;
    logic [7:0] compare_value_high;
    logic [7:0] period_register;
    logic [15:0] timer_one_count;
    logic timer_one_tick;
    logic [7:0] period_timer_count;
    logic [1:0] period_timer_sub;
    logic period_timer_wrap;
    logic match_interrupt_flag;
    logic special_event_trigger;
    logic timer_one_reset;
    logic pin_owned;
    logic pin_level;
    modport unit (input unit_control, input compare_value_low, input compare_value_high,
        input period_register, input timer_one_count, input timer_one_tick, input period_timer_count,
        input period_timer_sub, input period_timer_wrap, output match_interrupt_flag,
        output special_event_trigger, output timer_one_reset, output pin_owned, output pin_level);
    modport partner (output unit_control, output compare_value_low, output compare_value_high,
        output period_register, output timer_one_count, output timer_one_tick, output period_timer_count,
        output period_timer_sub, output period_timer_wrap, input match_interrupt_flag,
        input special_event_trigger, input timer_one_reset, input pin_owned, input pin_level);
endinterface
`default_nettype wire

/* File: design/ccpu_prescaler.sv */
// Purpose: free-running divider producing a one-cycle tick every div+1 clocks
// Assumes: div is stable while enabled
// Notes: used for timer one only; the period timer steps every clock
`timescale 1ns/10ps
`default_nettype none
module ccpu_prescaler
    import ccpu_pkg::*;
#(
    parameter int W = 4
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic enable,
    input wire logic [W-1:0] div,
    output logic tick
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } ccpu_ps_state_t;
    ccpu_ps_state_t st, next_st;
    // count up to div, then tick and restart
    always_comb begin
        next_st = st;
        tick = 1'b0;
        if (!enable) begin
            next_st.cnt = '0;
        end else if (st.cnt == div) begin
            next_st.cnt = '0;
            tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 1'b1;
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule
`default_nettype wire

/* File: design/ccpu_partner.sv */
// Purpose: partner end: software registers over avalon, timer one, period timer, adc trigger, pin
// Assumes: software follows the setup order for pin direction and timer modes
// Notes: writes take no wait state, reads wait while the data changes; waitrequest low whenever idle
`timescale 1ns/10ps
`default_nettype none
module ccpu_partner
    import ccpu_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    ccpu_link_if.partner link,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic adc_start,
    output logic pin_out,
    output logic pin_oe_n
);
    typedef struct packed {
        logic [7:0] control;
        logic [7:0] cmp_low;
        logic [7:0] cmp_high;
        logic [7:0] period;
        logic [7:0] tctrl;
        logic [1:0] flags;
        logic adc_req;
        logic [15:0] t1;
        logic [7:0] pt;
        logic [1:0] pt_sub;
        logic [31:0] rdata;
    } ccpu_part_state_t;
    ccpu_part_state_t st, next_st;
    logic t1_tick;
    logic pt_tick;
    logic pt_wrap;
    logic adc_pulse;
    // timer one prescale (one tick per instruction-rate step)
    ccpu_prescaler #(.W(4)) ccpu_prescaler_i (
        .clk(clk), .nrst(nrst), .enable(st.tctrl[CCPU_TC_T1_ON]),
        .div(st.tctrl[CCPU_TC_T1_DIV_LSB +: 4]), .tick(t1_tick));
    // period timer time base advances every clock (1:1 prescale)
    assign pt_tick = st.tctrl[CCPU_TC_PT_ON];
    assign pt_wrap = pt_tick && (st.pt == st.period) && (st.pt_sub == 2'h3);
    assign adc_pulse = link.special_event_trigger && st.tctrl[CCPU_TC_ADC_EN];
    // register, timer and flag next state
    always_comb begin
        next_st = st;
        if (avs_write) begin
            case (avs_address)
                CCPU_REG_CONTROL: next_st.control = avs_writedata[7:0];
                CCPU_REG_CMP_LOW: next_st.cmp_low = avs_writedata[7:0];
                CCPU_REG_CMP_HIGH: next_st.cmp_high = avs_writedata[7:0];
                CCPU_REG_PERIOD: next_st.period = avs_writedata[7:0];
                CCPU_REG_TIMER_CTRL: next_st.tctrl = avs_writedata[7:0];
                CCPU_REG_STATUS: next_st.flags = st.flags & ~avs_writedata[1:0];
                default: next_st.adc_req = st.adc_req;
            endcase
        end
        // timer one: trigger reset on its own tick, never setting the overflow flag
        if (link.timer_one_reset) begin
            next_st.t1 = '0;
        end else if (t1_tick) begin
            next_st.t1 = st.t1 + 16'h0001;
            if (st.t1 == 16'hFFFF) begin
                next_st.flags[CCPU_ST_OVF] = 1'b1;
            end
        end
        // period timer with 2-bit sub count forming the 10-bit base
        if (pt_wrap) begin
            next_st.pt = '0;
            next_st.pt_sub = '0;
        end else if (pt_tick) begin
            next_st.pt_sub = st.pt_sub + 2'h1;
            if (st.pt_sub == 2'h3) begin
                next_st.pt = st.pt + 8'h01;
            end
        end
        // hardware sets win over software clears
        if (link.match_interrupt_flag) begin
            next_st.flags[CCPU_ST_MATCH] = 1'b1;
        end
        if (adc_pulse) begin
            next_st.adc_req = ~st.adc_req;
        end
        case (avs_address)
            CCPU_REG_CONTROL: next_st.rdata = {24'h000000, st.control};
            CCPU_REG_CMP_LOW: next_st.rdata = {24'h000000, st.cmp_low};
            CCPU_REG_CMP_HIGH: next_st.rdata = {24'h000000, st.cmp_high};
            CCPU_REG_PERIOD: next_st.rdata = {24'h000000, st.period};
            CCPU_REG_TIMER_CTRL: next_st.rdata = {24'h000000, st.tctrl};
            CCPU_REG_STATUS: next_st.rdata = {28'h0000000, link.pin_level, st.adc_req, st.flags};
            CCPU_REG_TIMER_LOW: next_st.rdata = {24'h000000, st.t1[7:0]};
            default: next_st.rdata = {24'h000000, st.t1[15:8]};
        endcase
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    // drive the link and the avalon answer
    assign link.unit_control = st.control;
    assign link.compare_value_low = st.cmp_low;
    assign link.compare_value_high = st.cmp_high;
    assign link.period_register = st.period;
    assign link.timer_one_count = st.t1;
    assign link.timer_one_tick = t1_tick;
    assign link.period_timer_count = st.pt;
    assign link.period_timer_sub = st.pt_sub;
    assign link.period_timer_wrap = pt_wrap;
    assign avs_waitrequest = avs_read && (st.rdata != next_st.rdata);
    assign avs_readdata = st.rdata;
    assign adc_start = adc_pulse;
    // pin shows unit level when owned, else port low; enable is active low
    assign pin_out = link.pin_owned ? link.pin_level : 1'b0;
    assign pin_oe_n = 1'b0;
endmodule
`default_nettype wire

/* File: design/ccpu_unit.sv */
// Purpose: compare and standard pwm unit end
// Assumes: timer one runs synchronously and not from the raw system clock
// Notes: one instance per unit; four instances give the four units
`timescale 1ns/10ps
`default_nettype none

// compare path
// the 16-bit compare value is the high and low bytes joined
// it is checked against the timer one count on every clock
// only the first cycle of equality counts as a match
// a match held for many cycles acts once, not every cycle
// the match memory runs in every mode, so entering a mode
//   while the count already equals the value does not act

// compare actions
// toggle, set and clear work on the compare output latch
// the latch changes on the edge that ends the match cycle
// the match flag is a combinational pulse in that cycle
// the partner turns the pulse into a sticky status bit
// the sticky bit and the latch change on the same edge
// software interrupt mode raises the flag, keeps the latch
// trigger mode raises the flag and the trigger pulse
// the off mode and the pwm modes raise no flag
// codes outside the decoded set hold the latch

// special event trigger
// the trigger pulse lasts one clock, once per match
// the partner gates it with the adc enable
// the timer one reset waits for the next timer tick
// a pending reset is kept in one flip-flop
// the reset strobe needs the match to be still present
// moving the compare value away cancels the pending reset
// the reset clears the count and leaves overflow alone
// the partner keeps the reset apart from the carry out
// hazard: a timer ticking on every clock gets no reset,
//   the match is gone before the pending bit is set,
//   so timer one must run slower than this clock

// zero control
// a control value of zero clears the compare output latch
// it also drops any pending timer reset
// it hands the pin back to port control
// any other value leaves the unit active

// pin ownership
// the unit owns the pin in toggle, set, clear and pwm modes
// software interrupt and trigger modes never take the pin
// the off mode never takes it, whatever the duty bits say
// while not owned, pin_level still shows the latch
// pin direction belongs to the partner, not to this unit

// pwm time base
// the partner's 8-bit period count and 2-bit sub count
//   form the 10-bit time base
// the base is taken to advance once per clock (1:1)
// the wrap pulse marks the last cycle of a period
// on a wrap the requested duty is copied into the buffer
// on a wrap the pin is set for the next period,
//   unless the requested duty is zero

// pwm duty
// the requested duty is the compare low byte on top
//   and the two duty bits of the control value below
// the buffer holds the duty for a whole period,
//   so a write in mid-period cannot cause a glitch
// the pin is cleared one clock ahead of the base match,
//   so it is already low in the cycle of the match
// the pin is thus high for exactly duty clocks
// a duty of zero keeps the pin low for good
// a duty beyond the period leaves the pin high
// leaving pwm mode forces the pwm pin register low

// reset state
// all state clears on the asynchronous reset
// after reset the pin is not owned and the latch is low
// the match memory starts low, so a count equal to the
//   compare value at release gives one match at once;
//   with the mode off that match has no effect

// link outputs
// match_interrupt_flag: one-cycle combinational pulse
// special_event_trigger: one-cycle combinational pulse
// timer_one_reset: one-cycle pulse on a timer tick
// pin_owned: level, decoded from the control value
// pin_level: level, a choice between two flip-flops

// link inputs
// control, compare bytes and period come from registers
// the counts come from registers in the partner
// the tick and wrap strobes are combinational pulses
// all share this clock, so none needs a synchroniser

// mode codes
// 0 off, 2 toggle, 8 set, 9 clear
// A software interrupt, B special event trigger
// top two bits both set select pwm
// other codes raise the flag but move no latch

// limitations
// nothing here works with the clock stopped
// a stopped period timer can end a pulse one count early
// the four units are four instances of this module,
//   with no state shared between them
// the timer one count is not latched across its bytes

module ccpu_unit
    import ccpu_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    ccpu_link_if.unit link
);
    typedef struct packed {
        logic out_latch;
        logic matched;
        logic reset_pending;
        logic [9:0] duty_buf;
        logic pwm_pin;
    } ccpu_unit_state_t;
    ccpu_unit_state_t st, next_st;
    logic [3:0] mode;
    logic [15:0] cmp_value;
    logic match_now;
    logic match_edge;
    logic is_pwm;
    logic [9:0] duty_req;
    logic [9:0] time_base;
    logic [9:0] base_next;
    assign mode = link.unit_control[CCPU_MODE_LSB +: 4];
    assign cmp_value = {link.compare_value_high, link.compare_value_low};
    assign match_now = (cmp_value == link.timer_one_count);
    assign match_edge = match_now && !st.matched;
    assign is_pwm = (mode[3:2] == CCPU_MODE_PWM_TOP);
    assign duty_req = {link.compare_value_low, link.unit_control[CCPU_DUTY_LSB +: 2]};
    assign time_base = {link.period_timer_count, link.period_timer_sub};
    assign base_next = time_base + 10'h001; // time base of the next clock
    // compare actions, pending timer reset and pwm output
    always_comb begin
        next_st = st;
        next_st.matched = match_now;
        if (link.unit_control == CCPU_CONTROL_RESET) begin
            next_st.out_latch = 1'b0;
            next_st.reset_pending = 1'b0;
        end else if (match_edge && !is_pwm) begin
            case (mode)
                CCPU_MODE_TOGGLE: next_st.out_latch = ~st.out_latch;
                CCPU_MODE_SET: next_st.out_latch = 1'b1;
                CCPU_MODE_CLEAR: next_st.out_latch = 1'b0;
                CCPU_MODE_TRIGGER: next_st.reset_pending = 1'b1;
                default: next_st.out_latch = st.out_latch;
            endcase
        end
        if (st.reset_pending && !match_now) begin
            next_st.reset_pending = 1'b0;
        end else if (st.reset_pending && link.timer_one_tick) begin
            next_st.reset_pending = 1'b0;
        end
        // pwm: wrap sets pin and reloads buffer; pin is low once the base reaches duty
        if (is_pwm && link.period_timer_wrap) begin
            next_st.duty_buf = duty_req;
            next_st.pwm_pin = (duty_req != 10'h000);
        end else if (is_pwm && base_next == st.duty_buf) begin
            next_st.pwm_pin = 1'b0;
        end
        if (!is_pwm) begin
            next_st.pwm_pin = 1'b0;
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    // link outputs
    assign link.match_interrupt_flag = match_edge && (mode != CCPU_MODE_OFF) && !is_pwm;
    assign link.special_event_trigger = match_edge && (mode == CCPU_MODE_TRIGGER);
    // reset is a separate strobe the partner treats as non-overflow
    assign link.timer_one_reset = st.reset_pending && match_now && link.timer_one_tick;
    assign link.pin_owned = (link.unit_control != CCPU_CONTROL_RESET) && (mode != CCPU_MODE_OFF) && (mode != CCPU_MODE_SWINT)
        && (mode != CCPU_MODE_TRIGGER);
    assign link.pin_level = is_pwm ? st.pwm_pin : st.out_latch;
endmodule
`default_nettype wire

/* File: verification/ccpu_link_sva.sv */
// Purpose: checks the link between the compare/pwm unit and its partner
// Assumes: one clock, asynchronous active-low reset
// Notes: fed from the interface signals, no bind
`timescale 1ns/10ps
`default_nettype none
module ccpu_link_sva
    import ccpu_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] unit_control,
    input wire logic [7:0] compare_value_low,
    input wire logic [7:0] compare_value_high,
    input wire logic [15:0] timer_one_count,
    input wire logic timer_one_tick,
    input wire logic [7:0] period_timer_count,
    input wire logic [1:0] period_timer_sub,
    input wire logic period_timer_wrap,
    input wire logic match_interrupt_flag,
    input wire logic special_event_trigger,
    input wire logic timer_one_reset,
    input wire logic pin_owned,
    input wire logic pin_level
);
    logic [3:0] mode;
    logic eq, pwm, act, trg;
    logic [9:0] duty;
    logic [9:0] duty_held;
    // mode decode, compare equality and pwm duty
    assign mode = unit_control[3:0];
    assign eq = {compare_value_high, compare_value_low} == timer_one_count;
    assign pwm = mode[3:2] == CCPU_MODE_PWM_TOP;
    assign act = mode != CCPU_MODE_OFF && !pwm;
    assign trg = mode == CCPU_MODE_TRIGGER;
    assign duty = {compare_value_low, unit_control[5:4]};
    // duty copied at each wrap in pwm mode, as the unit buffers it for one period
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            duty_held <= '0;
        end else if (pwm && period_timer_wrap) begin
            duty_held <= duty;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_flag_on_match: assert property (match_interrupt_flag |-> eq && act) else $error("flag without match");
    a_flag_on_rise: assert property ($rose(eq) && act |-> match_interrupt_flag) else $error("match missed");
    a_trig_cause: assert property (special_event_trigger |-> match_interrupt_flag && trg) else $error("bad trigger");
    a_treset_cause: assert property (timer_one_reset |-> timer_one_tick && eq && trg) else $error("bad reset");
    a_treset_due: assert property (timer_one_tick && eq && trg && $past(eq) |-> timer_one_reset)
        else $error("timer reset missing");
    a_pin_released: assert property (mode == CCPU_MODE_OFF || mode == CCPU_MODE_SWINT || trg |-> !pin_owned)
        else $error("pin held");
    a_zero_latch: assert property (unit_control == 8'h00 |=> !pin_level) else $error("latch not cleared");
    a_toggle_flip: assert property (match_interrupt_flag && mode == CCPU_MODE_TOGGLE |=> pin_level != $past(pin_level))
        else $error("no toggle");
    a_pwm_set: assert property (pwm && period_timer_wrap && duty != 10'h000 |=> pin_level) else $error("pwm not set");
    a_pwm_clear: assert property (pwm && {period_timer_count, period_timer_sub} == duty_held
        && duty_held != 10'h000 |-> !pin_level) else $error("pwm not cleared");
    // main scenarios reached
    c_trigger: cover property (special_event_trigger);
    c_reset: cover property (timer_one_reset);
    c_wrap: cover property (pwm && period_timer_wrap);
endmodule
`default_nettype wire

/* File: verification/ccp_compare_and_pwm_unit_test.sv */
// Purpose: self-checking bench for the unit and its partner joined by the link
// Assumes: zero or one wait state avalon slave
// Notes: compare actions, trigger, cancelled reset and pwm duty
`timescale 1ns/10ps
`default_nettype none
module ccp_compare_and_pwm_unit_test
    import ccpu_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [2:0] avs_address = 3'h0;
    logic avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, adc_start, pin_out, pin_oe_n;
    logic [7:0] rd;
    logic [3:0] evs;
    logic [3:0] modes [4] = '{CCPU_MODE_SET, CCPU_MODE_CLEAR, CCPU_MODE_TOGGLE, CCPU_MODE_SWINT};
    logic [1:0] pin_exp [4] = '{2'h3, 2'h1, 2'h3, 2'h2};
    int n_fail = 0, n_tests = 0, cyc = 0, h;
    ccpu_link_if link ();
    ccpu_unit ccpu_unit_i (.clk(clk), .nrst(nrst), .link(link.unit));
    ccpu_partner ccpu_partner_i (.clk(clk), .nrst(nrst), .link(link.partner), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .adc_start(adc_start), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
    ccpu_link_sva ccpu_link_sva_i (.clk(clk), .nrst(nrst), .unit_control(link.unit_control),
        .compare_value_low(link.compare_value_low), .compare_value_high(link.compare_value_high),
        .timer_one_count(link.timer_one_count), .timer_one_tick(link.timer_one_tick),
        .period_timer_count(link.period_timer_count), .period_timer_sub(link.period_timer_sub),
        .period_timer_wrap(link.period_timer_wrap), .match_interrupt_flag(link.match_interrupt_flag),
        .special_event_trigger(link.special_event_trigger), .timer_one_reset(link.timer_one_reset),
        .pin_owned(link.pin_owned), .pin_level(link.pin_level));
    // clock and events to wait for
    always #4 clk = ~clk;
    assign evs = {link.period_timer_wrap, link.timer_one_tick, link.special_event_trigger, link.match_interrupt_flag};
    // cycle ceiling against a hang
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_fail++;
            results();
        end
    end
    // compare one value
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // verdict and end of run
    task automatic results();
        if (n_fail == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // one avalon access held until waitrequest is sampled low
    task automatic av(input logic w, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // wait for an event with a bound
    task automatic wait_ev(input int k);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (evs[k] !== 1'b1 && n < 1000);
        chk({15'h0, evs[k]}, 16'h0001);
    endtask
    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        av(1, CCPU_REG_TIMER_CTRL, 8'h15);
        chk({15'h0, pin_oe_n}, 16'h0000);
        av(1, CCPU_REG_CMP_LOW, 8'h10);
        av(1, CCPU_REG_CONTROL, {4'h0, CCPU_MODE_TRIGGER});
        wait_ev(1);
        chk(link.timer_one_count, 16'h0010);
        chk({15'h0, adc_start}, 16'h0001);
        wait_ev(2);
        chk({15'h0, link.timer_one_reset}, 16'h0001);
        @(negedge clk);
        chk(link.timer_one_count, 16'h0000);
        av(0, CCPU_REG_STATUS, 8'h00);
        chk({15'h0, rd[CCPU_ST_OVF]}, 16'h0000);
        chk({15'h0, rd[CCPU_ST_MATCH]}, 16'h0001);
        for (int i = 0; i < 4; i++) begin
            av(1, CCPU_REG_CMP_LOW, 8'(8'h40 * (i + 1)));
            if (i == 3) av(1, CCPU_REG_CMP_HIGH, 8'h01);
            av(1, CCPU_REG_CONTROL, {4'h0, modes[i]});
            wait_ev(0);
            @(negedge clk);
            chk({14'h0, link.pin_level, link.pin_owned}, {14'h0, pin_exp[i]});
        end
        av(1, CCPU_REG_CONTROL, 8'h00);
        repeat (2) @(negedge clk);
        chk({13'h0, link.pin_level, link.pin_owned, pin_out}, 16'h0000);
        av(1, CCPU_REG_TIMER_CTRL, 8'hF1);
        av(1, CCPU_REG_CMP_LOW, 8'h30);
        av(1, CCPU_REG_CONTROL, {4'h0, CCPU_MODE_TRIGGER});
        wait_ev(1);
        chk({15'h0, adc_start}, 16'h0000);
        av(1, CCPU_REG_CMP_LOW, 8'h50);
        wait_ev(2);
        chk({15'h0, link.timer_one_reset}, 16'h0000);
        @(negedge clk);
        chk(link.timer_one_count, 16'h0131);
        av(1, CCPU_REG_PERIOD, 8'h03);
        av(1, CCPU_REG_TIMER_CTRL, 8'h02);
        for (int j = 0; j < 2; j++) begin
            av(1, CCPU_REG_CMP_LOW, 8'(j));
            av(1, CCPU_REG_CONTROL, j ? 8'h2C : 8'h0C);
            wait_ev(3);
            wait_ev(3);
            h = 0;
            repeat (16) begin
                @(negedge clk);
                if (link.pin_level === 1'b1) h++;
            end
            chk(16'(h), j ? 16'h0006 : 16'h0000);
        end
        results();
    end
endmodule
`default_nettype wire
